// >>> hdl/scrb_cfg.svh
// Register map, field positions, reset values and constants of the synth channel bank.
// Assumes inclusion by bare name from the bank module and the bench.
`ifndef SCRB_CFG_SVH
`define SCRB_CFG_SVH
// Byte addresses on APB, one aligned word per register
`define SCRB_OFS_BAND 8'h00
`define SCRB_OFS_TX 8'h14
`define SCRB_OFS_R1 8'h18
`define SCRB_OFS_P1 8'h1C
`define SCRB_OFS_S1 8'h20
`define SCRB_OFS_R2 8'h24
`define SCRB_OFS_P2 8'h28
`define SCRB_OFS_S2 8'h2C
`define SCRB_OFS_CTL 8'h30
`define SCRB_OFS_IF2 8'h34
`define SCRB_OFS_STAT 8'h38
`define SCRB_OFS_FREQ 8'h3C
// Field positions
`define SCRB_BAND_MSB 4
`define SCRB_BAND_LSB 2
`define SCRB_RAMP_MSB 7
`define SCRB_RAMP_LSB 6
`define SCRB_SEL_BIT 0
`define SCRB_OOK_BIT 0
// Reset values
`define SCRB_RST_BYTE 8'h00
`define SCRB_RST_IF2 16'h0064
// Highest defined band code
`define SCRB_BAND_MAX 3'h5
// Ramp times in ns, OOK rise then fall, codes 00..11
`define SCRB_RISE_0 16'h09C4
`define SCRB_FALL_0 16'h07D0
`define SCRB_RISE_1 16'h1388
`define SCRB_FALL_1 16'h0BB8
`define SCRB_RISE_2 16'h2710
`define SCRB_FALL_2 16'h1770
`define SCRB_RISE_3 16'h4E20
`define SCRB_FALL_3 16'h2710
// Synthesizer formula: 14.4 MHz step as kHz, and the fixed 75 multiplier
`define SCRB_REF_KHZ 29'h0003840
`define SCRB_MULT 15'h004B
// Quotient bits produced by the serial divider
`define SCRB_DIV_BITS 5'h1D
`endif

// >>> hdl/scrb_pkg.sv
// Types for the synth channel bank: divider state and the whole register state.
// Assumes scrb_cfg.svh sits beside it.
`default_nettype none
package scrb_pkg;
    typedef enum logic [0:0] {SCRB_IDLE, SCRB_BUSY} scrb_div_st_t;

    typedef struct packed {
        logic [7:0] band_cfg;
        logic [7:0] tx_cfg;
        logic [1:0][7:0] div_r;
        logic [1:0][7:0] div_p;
        logic [1:0][7:0] div_s;
        logic [7:0] ctl;
        logic [15:0] if2_khz;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        scrb_div_st_t dst;
        logic [4:0] cnt;
        logic [28:0] dvd;
        logic [9:0] rem;
        logic [8:0] dvs;
        logic [28:0] quo;
        logic [40:0] key;
        logic [14:0] syn_n;
        logic [8:0] syn_d;
        logic syn_sel;
        logic [31:0] freq_khz;
        logic freq_valid;
        logic [3:0] ramp_onehot;
        logic [15:0] ook_rise_ns;
        logic [15:0] ook_fall_ns;
        logic [5:0] band_onehot;
        logic band_bad;
        logic order_bad;
    } scrb_state_t;
endpackage : scrb_pkg
`default_nettype wire

// >>> hdl/scrb_bank.sv
// Synth channel register bank: APB slave with two divider sets, set select, ramp and band.
// Assumes an APB master on pclk; synthesizer and PA regulator read the registered outputs.
// Notes on behaviour
// R01: Ramp field bits 7..6 decode to four ramps, 00 fastest, 11 slowest.
// R02: Host picks ramp near five percent of a bit period, 50/BR us.
// R03: Frequency equals 14.4*(75*(P+1)+S)/(R+1) MHz from the selected set.
// R04: Host keeps P,S in 0..255, R in 64..169, S below P+1.
// R05: Two divider sets of three byte registers, second set follows first.
// R06: Set-select bit 0 routes set one (0) or set two (1).
// R07: Band field bits 4..2 selects VCO range, codes 000..101.
// R08: Writes to the unselected set leave the active frequency untouched.
// R09: Host loads all three values of the idle set before toggling.
// R10: OOK frequency is the formula minus an offset matching the second IF.
// R11: Host never writes band codes 110 or 111.
`include "scrb_cfg.svh"
`default_nettype none
module scrb_bank (
    input wire logic pclk,                // 250 MHz clock
    input wire logic presetn,             // Async reset, active low
    input wire logic [7:0] paddr,         // APB byte address
    input wire logic psel,                // APB select
    input wire logic penable,             // APB access phase
    input wire logic pwrite,              // APB direction, high = write
    input wire logic [31:0] pwdata,       // APB write data
    input wire logic [3:0] pstrb,         // APB byte strobes
    output logic [31:0] prdata,           // APB read data
    output logic pready,                  // APB ready
    output logic pslverr,                 // APB error, unmapped address
    output logic [14:0] syn_n,            // Feedback count 75*(P+1)+S
    output logic [8:0] syn_d,             // Reference divide R+1
    output logic syn_set_sel,             // Set in use
    output logic [31:0] freq_khz,         // Channel frequency in kHz
    output logic freq_valid,              // Frequency result current
    output logic ook_mode,                // OOK operation selected
    output logic [3:0] ramp_onehot,       // PA regulator ramp select
    output logic [15:0] ook_rise_ns,      // OOK rise time
    output logic [15:0] ook_fall_ns,      // OOK fall time
    output logic [5:0] vco_band_onehot,   // VCO range select
    output logic band_reserved            // Band field holds 110 or 111
);
    import scrb_pkg::*;

    scrb_state_t q;
    scrb_state_t next_q;

    // True for every address that holds a register
    function automatic logic addr_hit(input logic [7:0] a);
        case (a)
            `SCRB_OFS_BAND, `SCRB_OFS_TX, `SCRB_OFS_R1, `SCRB_OFS_P1, `SCRB_OFS_S1,
            `SCRB_OFS_R2, `SCRB_OFS_P2, `SCRB_OFS_S2, `SCRB_OFS_CTL, `SCRB_OFS_IF2,
            `SCRB_OFS_STAT, `SCRB_OFS_FREQ: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    endfunction : addr_hit

    // Feedback count for one divider set
    function automatic logic [14:0] fb_count(input logic [7:0] p, input logic [7:0] s);
        fb_count = 15'(`SCRB_MULT * (15'(p) + 15'h0001)) + 15'(s);
    endfunction : fb_count

    logic access;
    logic wr;
    logic [7:0] act_r;
    logic [7:0] act_p;
    logic [7:0] act_s;
    logic [40:0] key_now;
    logic [9:0] rem_sh;
    logic [28:0] quo_fin;
    logic [2:0] band_code;

    // Selected set; the unselected one only feeds readback
    assign act_r = q.div_r[q.tx_cfg[`SCRB_SEL_BIT]]; // [R06]
    assign act_p = q.div_p[q.tx_cfg[`SCRB_SEL_BIT]]; // [R06]
    assign act_s = q.div_s[q.tx_cfg[`SCRB_SEL_BIT]]; // [R06]
    assign key_now = {act_r, act_p, act_s, q.ctl[`SCRB_OOK_BIT], q.if2_khz};
    assign access = psel && penable && !q.pready;
    assign wr = access && pwrite && addr_hit(paddr);
    assign rem_sh = {q.rem[8:0], q.dvd[28]};
    assign quo_fin = {q.quo[27:0], (rem_sh >= {1'b0, q.dvs})};
    assign band_code = q.band_cfg[`SCRB_BAND_MSB:`SCRB_BAND_LSB];

    // Next-state logic for bus, registers, decoders and divider
    always_comb begin
        next_q = q;
        next_q.pready = access;
        next_q.pslverr = access && !addr_hit(paddr);
        // Register writes land on the edge that raises pready, one edge before the access completes
        if (wr && pstrb[0]) begin
            case (paddr)
                `SCRB_OFS_BAND: next_q.band_cfg = pwdata[7:0];
                `SCRB_OFS_TX: next_q.tx_cfg = pwdata[7:0];
                `SCRB_OFS_R1: next_q.div_r[0] = pwdata[7:0]; // [R05]
                `SCRB_OFS_P1: next_q.div_p[0] = pwdata[7:0]; // [R05]
                `SCRB_OFS_S1: next_q.div_s[0] = pwdata[7:0]; // [R05]
                `SCRB_OFS_R2: next_q.div_r[1] = pwdata[7:0]; // [R05]
                `SCRB_OFS_P2: next_q.div_p[1] = pwdata[7:0]; // [R05]
                `SCRB_OFS_S2: next_q.div_s[1] = pwdata[7:0]; // [R05]
                `SCRB_OFS_CTL: next_q.ctl = pwdata[7:0];
                `SCRB_OFS_IF2: next_q.if2_khz[7:0] = pwdata[7:0];
                default: ;
            endcase
        end
        if (wr && pstrb[1] && paddr == `SCRB_OFS_IF2) begin
            next_q.if2_khz[15:8] = pwdata[15:8];
        end
        // Read mux; unmapped reads return zero with pslverr
        next_q.prdata = 32'h0000_0000;
        if (access && !pwrite) begin
            case (paddr)
                `SCRB_OFS_BAND: next_q.prdata = {24'h000000, q.band_cfg};
                `SCRB_OFS_TX: next_q.prdata = {24'h000000, q.tx_cfg};
                `SCRB_OFS_R1: next_q.prdata = {24'h000000, q.div_r[0]};
                `SCRB_OFS_P1: next_q.prdata = {24'h000000, q.div_p[0]};
                `SCRB_OFS_S1: next_q.prdata = {24'h000000, q.div_s[0]};
                `SCRB_OFS_R2: next_q.prdata = {24'h000000, q.div_r[1]};
                `SCRB_OFS_P2: next_q.prdata = {24'h000000, q.div_p[1]};
                `SCRB_OFS_S2: next_q.prdata = {24'h000000, q.div_s[1]};
                `SCRB_OFS_CTL: next_q.prdata = {24'h000000, q.ctl};
                `SCRB_OFS_IF2: next_q.prdata = {16'h0000, q.if2_khz};
                `SCRB_OFS_STAT: next_q.prdata = {28'h0000000, q.order_bad, q.band_bad,
                                                 q.freq_valid, q.syn_sel};
                `SCRB_OFS_FREQ: next_q.prdata = q.freq_khz;
                default: next_q.prdata = 32'h0000_0000;
            endcase
        end
        // Synthesizer words follow the selected set only
        next_q.syn_sel = q.tx_cfg[`SCRB_SEL_BIT]; // [R06]
        next_q.syn_n = fb_count(act_p, act_s); // [R03] [R08]
        next_q.syn_d = 9'(act_r) + 9'h001; // [R03] [R08]
        // Flag a set that breaks S < P+1 so software can see it
        next_q.order_bad = (act_s > act_p);
        // Ramp decode, 00 fastest to 11 slowest
        next_q.ramp_onehot = 4'h1 << q.tx_cfg[`SCRB_RAMP_MSB:`SCRB_RAMP_LSB]; // [R01]
        case (q.tx_cfg[`SCRB_RAMP_MSB:`SCRB_RAMP_LSB])
            2'h0: begin
                next_q.ook_rise_ns = `SCRB_RISE_0; // [R01]
                next_q.ook_fall_ns = `SCRB_FALL_0;
            end
            2'h1: begin
                next_q.ook_rise_ns = `SCRB_RISE_1; // [R01]
                next_q.ook_fall_ns = `SCRB_FALL_1;
            end
            2'h2: begin
                next_q.ook_rise_ns = `SCRB_RISE_2; // [R01]
                next_q.ook_fall_ns = `SCRB_FALL_2;
            end
            default: begin
                next_q.ook_rise_ns = `SCRB_RISE_3; // [R01]
                next_q.ook_fall_ns = `SCRB_FALL_3;
            end
        endcase
        // Band decode; reserved codes drive no band at all
        next_q.band_bad = (band_code > `SCRB_BAND_MAX); // [R07]
        next_q.band_onehot = (band_code > `SCRB_BAND_MAX) ? 6'h00
                                                          : 6'(6'h01 << band_code); // [R07]
        // Serial divider, restarts on any change of its inputs
        case (q.dst)
            SCRB_IDLE: begin
                if (key_now != q.key) begin
                    next_q.key = key_now;
                    next_q.dst = SCRB_BUSY;
                    next_q.freq_valid = 1'b0;
                    next_q.cnt = `SCRB_DIV_BITS - 5'h01;
                    next_q.dvd = 29'(`SCRB_REF_KHZ * 29'(fb_count(act_p, act_s))); // [R03]
                    next_q.dvs = 9'(act_r) + 9'h001; // [R03]
                    next_q.rem = 10'h000;
                    next_q.quo = 29'h00000000;
                end
            end
            SCRB_BUSY: begin
                // A change mid-divide restarts; stale results never show as valid
                if (key_now != q.key) begin
                    next_q.dst = SCRB_IDLE;
                end else begin
                    next_q.dvd = {q.dvd[27:0], 1'b0};
                    next_q.quo = quo_fin;
                    next_q.rem = (rem_sh >= {1'b0, q.dvs}) ? 10'(rem_sh - {1'b0, q.dvs})
                                                           : rem_sh;
                    next_q.cnt = q.cnt - 5'h01;
                    if (q.cnt == 5'h00) begin
                        next_q.dst = SCRB_IDLE;
                        next_q.freq_valid = 1'b1;
                        // OOK subtracts the second IF, clamped at zero
                        if (q.ctl[`SCRB_OOK_BIT]) begin
                            next_q.freq_khz = (quo_fin > 29'(q.if2_khz))
                                ? {3'h0, 29'(quo_fin - 29'(q.if2_khz))} : 32'h0000_0000; // [R10]
                        end else begin
                            next_q.freq_khz = {3'h0, quo_fin}; // [R03]
                        end
                    end
                end
            end
            default: next_q.dst = SCRB_IDLE;
        endcase
    end

    // State register; key starts at all ones so the first divide runs after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.key <= '1;
            q.if2_khz <= `SCRB_RST_IF2;
            q.ramp_onehot <= 4'h1;
            q.ook_rise_ns <= `SCRB_RISE_0;
            q.ook_fall_ns <= `SCRB_FALL_0;
            q.band_onehot <= 6'h01;
            q.syn_n <= `SCRB_MULT;
            q.syn_d <= 9'h001;
        end else begin
            q <= next_q;
        end
    end

    // Outputs straight from state flops
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign syn_n = q.syn_n;
    assign syn_d = q.syn_d;
    assign syn_set_sel = q.syn_sel;
    assign freq_khz = q.freq_khz;
    assign freq_valid = q.freq_valid;
    assign ook_mode = q.ctl[`SCRB_OOK_BIT];
    assign ramp_onehot = q.ramp_onehot;
    assign ook_rise_ns = q.ook_rise_ns;
    assign ook_fall_ns = q.ook_fall_ns;
    assign vco_band_onehot = q.band_onehot;
    assign band_reserved = q.band_bad;

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Helper: write to the set not in use, with select untouched
    logic wr_idle_set;
    assign wr_idle_set = wr && (paddr != `SCRB_OFS_TX) &&
        (q.tx_cfg[`SCRB_SEL_BIT] ? (paddr inside {`SCRB_OFS_R1, `SCRB_OFS_P1, `SCRB_OFS_S1})
                                 : (paddr inside {`SCRB_OFS_R2, `SCRB_OFS_P2, `SCRB_OFS_S2}));

    a_ramp_slowest: assert property ( // [R01]
        q.tx_cfg[7:6] == 2'h3 |=> q.ramp_onehot == 4'h8 && q.ook_rise_ns == 16'h4E20
                                  && q.ook_fall_ns == 16'h2710)
        else $error("slowest ramp code not decoded");
    a_ramp_fastest: assert property ( // [R01]
        q.tx_cfg[7:6] == 2'h0 |=> q.ramp_onehot == 4'h1 && q.ook_rise_ns == 16'h09C4)
        else $error("fastest ramp code not decoded");
    a_set_route: assert property ( // [R06]
        $stable(q.tx_cfg) [*2] |-> q.syn_sel == q.tx_cfg[0])
        else $error("set select not routed");
    a_set_values: assert property ( // [R05]
        ##1 q.syn_d == 9'($past(q.div_r[q.tx_cfg[0]])) + 9'h001)
        else $error("reference divide not from selected set");
    a_idle_write: assert property ( // [R08]
        wr_idle_set ##1 !wr |=> $stable(q.syn_n) && $stable(q.syn_d))
        else $error("idle set write moved the active frequency");
    a_band_map: assert property ( // [R07]
        q.band_cfg[4:2] == 3'h5 |=> q.band_onehot == 6'h20 && !q.band_bad)
        else $error("band code 101 not decoded");
    a_band_rsvd: assert property ( // [R07]
        q.band_cfg[4:2] == 3'h7 |=> q.band_onehot == 6'h00 && q.band_bad)
        else $error("reserved band code drives a band");
    a_div_bound: assert property ( // [R03]
        (q.dst == SCRB_IDLE && key_now != q.key) ##1 (key_now == q.key) [*8]
        |-> ##[1:30] q.freq_valid || key_now != q.key)
        else $error("frequency not ready in time");
    a_ook_offset: assert property ( // [R10]
        q.dst == SCRB_BUSY && q.cnt == 5'h00 && key_now == q.key && q.ctl[0]
        && quo_fin > 29'(q.if2_khz) |=> q.freq_khz == {3'h0, $past(quo_fin) - 29'($past(q.if2_khz))})
        else $error("OOK offset not applied");
    // Bus answers once per access: ready for one cycle, never held
    a_ready_pulse: assert property (
        access |=> q.pready ##1 !q.pready)
        else $error("ready not a one-cycle pulse");
    // Unmapped address completes with an error and zero data
    a_unmapped_err: assert property (
        access && !addr_hit(paddr) |=> q.pslverr && q.prdata == 32'h0000_0000)
        else $error("unmapped access without error");
    a_ramp_mid: assert property ( // [R01]
        q.tx_cfg[7:6] == 2'h1 |=> q.ramp_onehot == 4'h2 && q.ook_rise_ns == 16'h1388
                                  && q.ook_fall_ns == 16'h0BB8)
        else $error("ramp code 01 not decoded");
    a_ramp_slow: assert property ( // [R01]
        q.tx_cfg[7:6] == 2'h2 |=> q.ramp_onehot == 4'h4 && q.ook_rise_ns == 16'h2710
                                  && q.ook_fall_ns == 16'h1770)
        else $error("ramp code 10 not decoded");
    // Both sets land where they are addressed, byte lane zero only
    a_set_two_land: assert property ( // [R05]
        wr && pstrb[0] && paddr == `SCRB_OFS_P2 |=> q.div_p[1] == $past(pwdata[7:0]))
        else $error("second set P write lost");
    a_set_one_land: assert property ( // [R05]
        wr && pstrb[0] && paddr == `SCRB_OFS_S1 |=> q.div_s[0] == $past(pwdata[7:0]))
        else $error("first set S write lost");
    a_sel_switch: assert property ( // [R06]
        $changed(q.tx_cfg[0]) |=> q.syn_sel == $past(q.tx_cfg[0]))
        else $error("set select change not followed");
    a_band_low: assert property ( // [R07]
        q.band_cfg[4:2] == 3'h0 |=> q.band_onehot == 6'h01 && !q.band_bad)
        else $error("band code 000 not decoded");
    // A change of inputs always withdraws the old result first
    a_valid_drop: assert property ( // [R03]
        q.dst == SCRB_IDLE && key_now != q.key |=> !q.freq_valid)
        else $error("stale frequency shown as valid");
    a_fsk_result: assert property ( // [R03]
        q.dst == SCRB_BUSY && q.cnt == 5'h00 && key_now == q.key && !q.ctl[0]
        |=> q.freq_valid && q.freq_khz == {3'h0, $past(quo_fin)})
        else $error("FSK result not published");
endmodule : scrb_bank
`default_nettype wire

// >>> tb/scrb_host.sv
// Host controller model: APB master that programs the synth channel bank.
// Assumes an APB slave on pclk that answers with pready; one transfer at a time.
`default_nettype none
module scrb_host (
    input wire logic pclk,            // Bus clock
    input wire logic [31:0] prdata,   // Read data
    input wire logic pready,          // Slave ready
    input wire logic pslverr,         // Slave error
    output logic [7:0] paddr,         // Byte address
    output logic psel,                // Select
    output logic penable,             // Access phase
    output logic pwrite,              // High = write
    output logic [31:0] pwdata,       // Write data
    output logic [3:0] pstrb          // Byte strobes
);
    timeunit 1ns;
    timeprecision 1ps;
    // Bus idle from time zero
    initial begin
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
        pstrb = 4'h0;
    end
    // One transfer; request held until pready is sampled high at a rising edge
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        paddr <= addr;
        pwrite <= wr;
        pwdata <= data;
        pstrb <= 4'hF;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk iff pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    // Whole set loaded before any toggle; out-of-range values never sent
    task automatic load_set(input logic set, input logic [7:0] r, p, s);
        logic [31:0] rd;
        logic err;
        if (r >= 8'h40 && r <= 8'hA9 && s <= p) begin
            xfer(1'b1, set ? `SCRB_OFS_R2 : `SCRB_OFS_R1, {24'h0, r}, rd, err);
            xfer(1'b1, set ? `SCRB_OFS_P2 : `SCRB_OFS_P1, {24'h0, p}, rd, err);
            xfer(1'b1, set ? `SCRB_OFS_S2 : `SCRB_OFS_S1, {24'h0, s}, rd, err);
        end
    endtask : load_set
    // Ramp near five percent of a bit: 50/rate us, nearest table step below
    function automatic logic [1:0] ramp_for_rate(input int kbps);
        int t_us;
        t_us = 50 / kbps;
        return (t_us >= 20) ? 2'h3 : (t_us >= 10) ? 2'h2 : (t_us >= 5) ? 2'h1 : 2'h0;
    endfunction : ramp_for_rate
endmodule : scrb_host
`default_nettype wire

// >>> tb/synth_channel_register_bank_bench.sv
// Self-checking bench for the synth channel bank, driven through the host model.
// Assumes scrb_cfg.svh on the include path; band codes 110/111 are never sent.
`include "scrb_cfg.svh"
`default_nettype none
module synth_channel_register_bank_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr;
    logic psel, penable, pwrite, pready, pslverr, syn_set_sel, freq_valid, ook_mode;
    logic [31:0] pwdata, prdata, freq_khz;
    logic [3:0] pstrb, ramp_onehot;
    logic [14:0] syn_n;
    logic [8:0] syn_d;
    logic [15:0] ook_rise_ns, ook_fall_ns;
    logic [5:0] vco_band_onehot;
    logic band_reserved;
    int error_cnt = 0;
    int checked = 0;
    int cycles = 0;
    scrb_bank dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .syn_n(syn_n), .syn_d(syn_d),
        .syn_set_sel(syn_set_sel), .freq_khz(freq_khz), .freq_valid(freq_valid),
        .ook_mode(ook_mode), .ramp_onehot(ramp_onehot), .ook_rise_ns(ook_rise_ns),
        .ook_fall_ns(ook_fall_ns), .vco_band_onehot(vco_band_onehot),
        .band_reserved(band_reserved));
    scrb_host host_u (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb));
    // 250 MHz clock
    always #2 pclk = ~pclk;
    // Hang guard: whole run needs well under a thousand cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        if (error_cnt == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        logic [31:0] rd;
        logic err;
        host_u.xfer(1'b1, addr, data, rd, err);
        repeat (2) @(posedge pclk);
    endtask : wr
    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input logic e_err);
        logic [31:0] rd;
        logic err;
        host_u.xfer(1'b0, addr, 32'h0, rd, err);
        cmp(rd, exp);
        cmp({31'h0, err}, {31'h0, e_err});
    endtask : rd_chk
    // Divider restarts on any change; bounded wait for the new result
    task automatic wait_valid;
        int n;
        n = 0;
        repeat (3) @(posedge pclk);
        while (freq_valid !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        cmp({31'h0, freq_valid}, 32'h1);
    endtask : wait_valid
    task automatic t_ramp;
        int rate [4] = '{25, 10, 5, 2};
        logic [15:0] rise [4] = '{16'h09C4, 16'h1388, 16'h2710, 16'h4E20};
        logic [15:0] fall [4] = '{16'h07D0, 16'h0BB8, 16'h1770, 16'h2710};
        logic [1:0] code;
        for (int i = 0; i < 4; i++) begin
            code = host_u.ramp_for_rate(rate[i]);
            wr(`SCRB_OFS_TX, {24'h0, code, 6'h00});
            cmp(32'(ramp_onehot), 32'h1 << i);
            cmp({ook_rise_ns, ook_fall_ns}, {rise[i], fall[i]});
        end
        rd_chk(`SCRB_OFS_TX, 32'h000000C0, 1'b0);
    endtask : t_ramp
    task automatic t_band;
        for (int i = 0; i < 6; i++) begin
            wr(`SCRB_OFS_BAND, 32'(i) << 2);
            cmp({26'h0, vco_band_onehot}, 32'h1 << i);
            cmp({31'h0, band_reserved}, 32'h0);
        end
    endtask : t_band
    // Hop sequence: run on set one, reload set two, then switch over
    task automatic t_sets;
        host_u.load_set(1'b0, 8'h77, 8'h22, 8'h00);
        host_u.load_set(1'b1, 8'h6B, 8'h2A, 8'h1E);
        wr(`SCRB_OFS_TX, 32'h0);
        wait_valid();
        cmp({2'h0, syn_n, 6'h0, syn_d}, {2'h0, 15'd2625, 6'h0, 9'd120});
        cmp(freq_khz, 32'd315000);
        rd_chk(`SCRB_OFS_R1, 32'h77, 1'b0);
        rd_chk(`SCRB_OFS_S2, 32'h1E, 1'b0);
        host_u.load_set(1'b1, 8'h8F, 8'h3A, 8'h2D);
        repeat (5) @(posedge pclk);
        cmp({31'h0, freq_valid}, 32'h1);
        cmp({17'h0, syn_n}, 32'd2625);
        cmp(freq_khz, 32'd315000);
        wr(`SCRB_OFS_TX, 32'h1);
        wait_valid();
        cmp({31'h0, syn_set_sel}, 32'h1);
        cmp({syn_n, 8'h0, syn_d}, {15'd4470, 8'h0, 9'd144});
        cmp(freq_khz, 32'd447000);
    endtask : t_sets
    task automatic t_ook;
        wr(`SCRB_OFS_CTL, 32'h1);
        wait_valid();
        cmp({31'h0, ook_mode}, 32'h1);
        cmp(freq_khz, 32'd446900);
        wr(`SCRB_OFS_IF2, 32'h000000C8);
        wait_valid();
        cmp(freq_khz, 32'd446800);
        rd_chk(`SCRB_OFS_IF2, 32'h000000C8, 1'b0);
        wr(`SCRB_OFS_CTL, 32'h0);
        wait_valid();
        cmp({31'h0, ook_mode}, 32'h0);
        cmp(freq_khz, 32'd447000);
        rd_chk(`SCRB_OFS_FREQ, 32'd447000, 1'b0);
        rd_chk(`SCRB_OFS_STAT, 32'h00000003, 1'b0);
    endtask : t_ook
    initial begin
        repeat (6) @(posedge pclk);
        cmp(32'(syn_n), 32'd75);
        presetn <= 1'b1;
        cmp({17'h0, syn_n}, 32'd75);
        cmp({23'h0, syn_d}, 32'd1);
        t_ramp();
        t_band();
        t_sets();
        t_ook();
        rd_chk(8'h04, 32'h0, 1'b1);
        tally_and_finish();
    end
endmodule : synth_channel_register_bank_bench
`default_nettype wire
